/* File: core/conversion_clock_select_consts.svh */
// constants of the converter sequencer: offsets, fields, resets, timing
// What the document asks of this block and its software
// R1 - result pair is not cleared by reset; only power-on or brownout makes it unknown
// R2 - an optional programmed acquisition sits between run flag set and conversion
// R3 - software waits two bit periods after a conversion before next acquisition
// R4 - acquisition field bits five to three selects 2 to 20 bit periods
// R5 - nonzero acquisition: sample for chosen periods then convert automatically
// R6 - zero acquisition: run flag stops sampling and starts conversion at once
// R7 - acquisition field resets to manual setting
// R8 - at completion clear run flag, set done flag, resume sampling
// R9 - no status separates acquisition from conversion; run flag covers both
// R10 - a twelve-bit conversion takes thirteen bit periods
// R11 - clock field picks 2,4,8,16,32,64 oscillator periods or RC source
// R12 - software picks shortest clock setting above minimum bit period
// R13 - RC clock above 1 MHz needs Sleep or a divider setting
// R14 - compare trigger sets run flag only in mode 1011 with converter enabled
// R15 - compare trigger clears the associated timer counter
// R16 - disabled converter ignores trigger, timer still cleared
// R17 - software makes every analog pin an input
// R18 - software configures, enables, sets run flag, waits, reads result
// R19 - channel field bits five to two selects channels 0 to 12
// R20 - enable bit zero switches converter; run flag meaningful only when enabled
// R21 - reset returns control registers, turns converter off, aborts conversion
// R22 - completion writes the twelve-bit result into the result pair
// R23 - justify bit right- or left-aligns result, zero padded
// R24 - one bit per bit period from msb down; extra period holds and transfers (here the first period sets the msb trial, transfer is with bit 0)
`ifndef CONVERSION_CLOCK_SELECT_CONSTS_SVH
`define CONVERSION_CLOCK_SELECT_CONSTS_SVH

// ************************************
// register byte offsets
// ************************************
`define CONVERSION_CLOCK_SELECT_OFF_RESH    12'h000
`define CONVERSION_CLOCK_SELECT_OFF_RESL    12'h004
`define CONVERSION_CLOCK_SELECT_OFF_CTRL0   12'h008
`define CONVERSION_CLOCK_SELECT_OFF_CFG1    12'h00C
`define CONVERSION_CLOCK_SELECT_OFF_CFG2    12'h010
`define CONVERSION_CLOCK_SELECT_OFF_STAT    12'h014

// ************************************
// field positions
// ************************************
`define CONVERSION_CLOCK_SELECT_CTRL0_ON    0
`define CONVERSION_CLOCK_SELECT_CTRL0_GO    1
`define CONVERSION_CLOCK_SELECT_CFG2_JUST   7
`define CONVERSION_CLOCK_SELECT_STAT_DONE   0

// ************************************
// reset values and masks
// ************************************
`define CONVERSION_CLOCK_SELECT_CTRL0_RST   8'h00
`define CONVERSION_CLOCK_SELECT_CFG1_RST    8'h00
`define CONVERSION_CLOCK_SELECT_CFG2_RST    8'h00
`define CONVERSION_CLOCK_SELECT_CTRL0_MASK  8'h3F
`define CONVERSION_CLOCK_SELECT_CFG1_MASK   8'h3F
`define CONVERSION_CLOCK_SELECT_CFG2_MASK   8'hBF
`define CONVERSION_CLOCK_SELECT_TRIG_MODE   4'hB

// ************************************
// timing
// ************************************
`define CONVERSION_CLOCK_SELECT_CONV_PERIODS 4'hD
`define CONVERSION_CLOCK_SELECT_RC_DIV_DEF   250

`endif

/* File: core/conversion_clock_select_pkg.sv */
// types of the converter sequencer
package conversion_clock_select_pkg;
    typedef enum logic [1:0] {ST_SAMPLE, ST_ACQ, ST_CONV} conversion_clock_select_state_t;
endpackage

/* File: core/conversion_clock_select_top.sv */
// converter sequencer with apb register file
`include "conversion_clock_select_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module conversion_clock_select_top #(
    parameter int RC_DIV = `CONVERSION_CLOCK_SELECT_RC_DIV_DEF
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        special_trigger,
    input  wire logic [3:0]  compare_mode_field,
    input  wire logic        comparator_in,
    output logic             timer_clear,
    output logic             sample_enable,
    output logic [3:0]       channel_select,
    output logic [11:0]      dac_code,
    output logic             conversion_done_flag
);

    // ************************************
    // synchronisers for pins
    // ************************************
    logic [1:0] trig_sync_q;
    logic       cmp_q;
    logic       trig_prev_q;
    logic       trig_pulse;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_sync_q <= 2'h0;
            cmp_q       <= 1'b0;
            trig_prev_q <= 1'b0;
        end
        else
        begin
            trig_sync_q <= {trig_sync_q[0], special_trigger};
            cmp_q       <= comparator_in; // one stage only, two would not fit a two-period bit
            trig_prev_q <= trig_sync_q[1];
        end
    end

    assign trig_pulse = trig_sync_q[1] & ~trig_prev_q;

    // ************************************
    // registers and sequencer state
    // ************************************
    logic [7:0]  ctrl0_q, ctrl0_d;
    logic [7:0]  cfg1_q, cfg1_d;
    logic [7:0]  cfg2_q, cfg2_d;
    logic        done_q, done_d;
    conversion_clock_select_pkg::conversion_clock_select_state_t st_q, st_d;
    logic [5:0]  div_q, div_d;
    logic [7:0]  rc_q, rc_d;
    logic [4:0]  per_q, per_d;
    logic [11:0] sar_q, sar_d, res_q, res_d;
    logic [3:0]  bit_q, bit_d;
    logic        tclr_q, tclr_d;
    logic [31:0] prdata_d;
    logic        pslverr_d;
    logic        tick;
    logic [5:0]  div_max;
    logic [4:0]  acq_len;
    logic        wr_acc;
    logic        rd_acc;
    logic        conv_end;
    logic [15:0] res_word;

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;

    // R11
    always_comb
    begin
        case ({cfg2_q[2], cfg2_q[0]})
            2'b00:   div_max = 6'h01;
            2'b10:   div_max = 6'h03;
            2'b01:   div_max = 6'h07;
            2'b11:   div_max = 6'h0F;
            default: div_max = 6'h01;
        endcase
        if (cfg2_q[1])
            div_max = cfg2_q[2] ? 6'h3F : 6'h1F;
    end

    // R4
    always_comb
    begin
        case (cfg2_q[5:3])
            3'h1:    acq_len = 5'h02;
            3'h2:    acq_len = 5'h04;
            3'h3:    acq_len = 5'h06;
            3'h4:    acq_len = 5'h08;
            3'h5:    acq_len = 5'h0C;
            3'h6:    acq_len = 5'h10;
            3'h7:    acq_len = 5'h14;
            default: acq_len = 5'h00;
        endcase
    end

    // R23
    always_comb
    begin
        if (cfg2_q[`CONVERSION_CLOCK_SELECT_CFG2_JUST])
            res_word = {4'h0, res_q};
        else
            res_word = {res_q, 4'h0}; // R23
    end

    // ************************************
    // next state
    // ************************************
    always_comb
    begin
        ctrl0_d   = ctrl0_q;
        cfg1_d    = cfg1_q;
        cfg2_d    = cfg2_q;
        done_d    = done_q;
        st_d      = st_q;
        div_d     = div_q;
        rc_d      = rc_q;
        per_d     = per_q;
        sar_d     = sar_q;
        res_d     = res_q;
        bit_d     = bit_q;
        tclr_d    = 1'b0;
        prdata_d  = prdata;
        tick      = 1'b0;

        // bit period divider, RC source stands in as a fixed slow divider
        if (cfg2_q[1] && cfg2_q[0])
        begin
            if (rc_q == 8'(RC_DIV - 1))
            begin
                rc_d = 8'h00;
                tick = 1'b1;
            end
            else
                rc_d = rc_q + 8'h01;
        end
        else if (div_q == div_max)
        begin
            div_d = 6'h00;
            tick  = 1'b1;
        end
        else
            div_d = div_q + 6'h01;
        if (st_q == conversion_clock_select_pkg::ST_SAMPLE)
        begin
            div_d = 6'h00;
            rc_d  = 8'h00;
            tick  = 1'b0;
        end
        conv_end = tick && st_q == conversion_clock_select_pkg::ST_CONV && per_q == 5'(`CONVERSION_CLOCK_SELECT_CONV_PERIODS - 1);
        // R15 R16
        if (trig_pulse && compare_mode_field == `CONVERSION_CLOCK_SELECT_TRIG_MODE)
            tclr_d = 1'b1;

        if (wr_acc)
        begin
            case (paddr)
                `CONVERSION_CLOCK_SELECT_OFF_CTRL0: ctrl0_d = pwdata[7:0] & `CONVERSION_CLOCK_SELECT_CTRL0_MASK;
                `CONVERSION_CLOCK_SELECT_OFF_CFG1:  cfg1_d  = pwdata[7:0] & `CONVERSION_CLOCK_SELECT_CFG1_MASK;
                `CONVERSION_CLOCK_SELECT_OFF_CFG2:  cfg2_d  = pwdata[7:0] & `CONVERSION_CLOCK_SELECT_CFG2_MASK;
                `CONVERSION_CLOCK_SELECT_OFF_STAT:  done_d  = pwdata[`CONVERSION_CLOCK_SELECT_STAT_DONE];
                `CONVERSION_CLOCK_SELECT_OFF_RESH, `CONVERSION_CLOCK_SELECT_OFF_RESL: ;
                default:         ;
            endcase
        end

        // R14
        if (trig_pulse && compare_mode_field == `CONVERSION_CLOCK_SELECT_TRIG_MODE && ctrl0_q[`CONVERSION_CLOCK_SELECT_CTRL0_ON])
            ctrl0_d[`CONVERSION_CLOCK_SELECT_CTRL0_GO] = 1'b1;

        case (st_q)
            conversion_clock_select_pkg::ST_SAMPLE:
            begin
                if (ctrl0_q[`CONVERSION_CLOCK_SELECT_CTRL0_GO] && ctrl0_q[`CONVERSION_CLOCK_SELECT_CTRL0_ON])
                begin
                    per_d = 5'h00;
                    bit_d = 4'hB;
                    sar_d = 12'h000;
                    if (acq_len == 5'h00)
                        st_d = conversion_clock_select_pkg::ST_CONV; // R6
                    else
                        st_d = conversion_clock_select_pkg::ST_ACQ; // R2 R5
                end
            end
            conversion_clock_select_pkg::ST_ACQ:
            begin
                if (tick)
                begin
                    if (per_d == acq_len - 5'h01 || per_q == acq_len - 5'h01)
                    begin
                        per_d = 5'h00;
                        st_d  = conversion_clock_select_pkg::ST_CONV;
                    end
                    else
                        per_d = per_q + 5'h01;
                end
            end
            conversion_clock_select_pkg::ST_CONV:
            begin
                if (tick)
                begin
                    per_d = per_q + 5'h01;
                    if (per_q == 5'h00)
                        sar_d[11] = 1'b1;
                    else if (per_q <= 5'h0C)
                    begin
                        // R24
                        sar_d[bit_q] = cmp_q;
                        if (bit_q != 4'h0)
                        begin
                            sar_d[bit_q - 4'h1] = 1'b1;
                            bit_d = bit_q - 4'h1;
                        end
                    end
                end
                if (conv_end) // R10
                begin
                    st_d   = conversion_clock_select_pkg::ST_SAMPLE;
                    ctrl0_d[`CONVERSION_CLOCK_SELECT_CTRL0_GO] = 1'b0; // R8
                    res_d = sar_d; // R22
                end
            end
            default: st_d = conversion_clock_select_pkg::ST_SAMPLE;
        endcase

        // R20 R21
        if (!ctrl0_d[`CONVERSION_CLOCK_SELECT_CTRL0_ON])
        begin
            st_d = conversion_clock_select_pkg::ST_SAMPLE;
            ctrl0_d[`CONVERSION_CLOCK_SELECT_CTRL0_GO] = 1'b0;
        end

        if (conv_end)
            done_d = 1'b1; // R8

        if (rd_acc)
        begin
            case (paddr)
                `CONVERSION_CLOCK_SELECT_OFF_RESH:  prdata_d = {24'h0, res_word[15:8]};
                `CONVERSION_CLOCK_SELECT_OFF_RESL:  prdata_d = {24'h0, res_word[7:0]};
                `CONVERSION_CLOCK_SELECT_OFF_CTRL0: prdata_d = {24'h0, ctrl0_q}; // R9
                `CONVERSION_CLOCK_SELECT_OFF_CFG1:  prdata_d = {24'h0, cfg1_q};
                `CONVERSION_CLOCK_SELECT_OFF_CFG2:  prdata_d = {24'h0, cfg2_q};
                `CONVERSION_CLOCK_SELECT_OFF_STAT:  prdata_d = {31'h0, done_q};
                default:         prdata_d = 32'h0000_0000;
            endcase
        end
        if (psel && !penable)
            pslverr_d = !(paddr inside {`CONVERSION_CLOCK_SELECT_OFF_RESH, `CONVERSION_CLOCK_SELECT_OFF_RESL, `CONVERSION_CLOCK_SELECT_OFF_CTRL0,
                `CONVERSION_CLOCK_SELECT_OFF_CFG1, `CONVERSION_CLOCK_SELECT_OFF_CFG2, `CONVERSION_CLOCK_SELECT_OFF_STAT});
        else
            pslverr_d = pslverr;
    end

    // ************************************
    // control flops, cleared by reset
    // ************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_q <= `CONVERSION_CLOCK_SELECT_CTRL0_RST;
            cfg1_q  <= `CONVERSION_CLOCK_SELECT_CFG1_RST;
            cfg2_q  <= `CONVERSION_CLOCK_SELECT_CFG2_RST; // R7
            done_q  <= 1'b0;
            st_q    <= conversion_clock_select_pkg::ST_SAMPLE;
            div_q   <= 6'h00;
            rc_q    <= 8'h00;
            per_q   <= 5'h00;
            bit_q   <= 4'h0;
            tclr_q  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl0_q <= ctrl0_d;
            cfg1_q  <= cfg1_d;
            cfg2_q  <= cfg2_d;
            done_q  <= done_d;
            st_q    <= st_d;
            div_q   <= div_d;
            rc_q    <= rc_d;
            per_q   <= per_d;
            bit_q   <= bit_d;
            tclr_q  <= tclr_d;
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
        end
    end

    // result survives reset, it only matters after a completed conversion
    always_ff @(posedge pclk)
    begin
        sar_q <= sar_d;
        res_q <= res_d; // R1 R22
    end

    // ************************************
    // outputs
    // ************************************
    logic        samp_q;
    logic [3:0]  chan_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            samp_q <= 1'b1;
            chan_q <= 4'h0;
        end
        else
        begin
            pready <= psel & ~penable;
            samp_q <= (st_d != conversion_clock_select_pkg::ST_CONV);
            chan_q <= ctrl0_d[5:2]; // R19
        end
    end

    assign sample_enable        = samp_q;
    assign channel_select       = chan_q;
    assign dac_code             = sar_q;
    assign timer_clear          = tclr_q;
    assign conversion_done_flag = done_q;

endmodule
`default_nettype wire

/* File: tb/conversion_clock_select_checker_assertions.sv */
// port checker of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "conversion_clock_select_consts.svh"
module conversion_clock_select_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        special_trigger,
    input wire logic [3:0]  compare_mode_field,
    input wire logic        timer_clear,
    input wire logic        sample_enable,
    input wire logic        conversion_done_flag
);
    logic       en_q;
    logic       en_d;
    logic [2:0] acq_q;
    logic [2:0] acq_d;
    logic       wr;
    logic       go;
    logic       trg;
    assign wr = psel && penable && pready && pwrite;
    assign go = wr && paddr == `CONVERSION_CLOCK_SELECT_OFF_CTRL0 && pwdata[1:0] == 2'h3;
    assign trg = special_trigger && (!en_q || compare_mode_field != `CONVERSION_CLOCK_SELECT_TRIG_MODE);
    always_comb
    begin
        en_d = wr && paddr == `CONVERSION_CLOCK_SELECT_OFF_CTRL0 ? pwdata[0] : en_q;
        acq_d = wr && paddr == `CONVERSION_CLOCK_SELECT_OFF_CFG2 ? pwdata[5:3] : acq_q;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {en_q, acq_q} <= 4'h0;
        else
            {en_q, acq_q} <= {en_d, acq_d};
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // *********
    // assertions
    // *********
    ready_access_a:
        assert property (psel && !penable |=> pready) else $error("no pready");
    manual_start_a:
        assert property (go && acq_q == 3'h0 |-> ##[1:3] !sample_enable) else $error("late");
    acq_hold_a:
        assert property (go && acq_q != 3'h0 |-> sample_enable [*4]) else $error("acq short");
    trig_ignored_a:
        assert property ($rose(trg) && sample_enable |-> sample_enable [*8]) else $error("ran");
    timer_clear_a:
        assert property ($rose(special_trigger) && compare_mode_field == 4'hB
            |-> ##[1:4] timer_clear) else $error("no timer clear");
    clear_pulse_a:
        assert property (timer_clear |=> !timer_clear) else $error("long clear");
    conv_length_a:
        assert property ($fell(sample_enable) |-> !sample_enable [*8]) else $error("short");
    resume_done_a:
        assert property ($rose(sample_enable) |-> ##[0:1] conversion_done_flag)
        else $error("no done flag");
    cover property ($rose(conversion_done_flag));
    cover property (timer_clear);
    cover property (go && acq_q != 3'h0);
endmodule
bind conversion_clock_select_top conversion_clock_select_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .special_trigger(special_trigger), .compare_mode_field(compare_mode_field),
    .timer_clear(timer_clear), .sample_enable(sample_enable),
    .conversion_done_flag(conversion_done_flag));
`default_nettype wire

/* File: tb/conversion_clock_select_analog_model.sv */
// analog inputs: level per channel, sample and hold, comparator
`timescale 1ns/1ps
`default_nettype none
module conversion_clock_select_analog_model (
    input  wire logic        pclk,
    input  wire logic        sample_enable,
    input  wire logic [3:0]  channel_select,
    input  wire logic [11:0] dac_code,
    output logic             comparator_in
);
    logic [11:0] held_q;
    logic [11:0] held_d;
    // held while converting, so a channel change cannot corrupt a result
    always_comb
        held_d = sample_enable ? {channel_select, 8'hA5} : held_q;
    always_ff @(posedge pclk)
        held_q <= held_d;
    assign comparator_in = held_q >= dac_code;
endmodule
`default_nettype wire

/* File: tb/test_adc_conversion_sequencer.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "conversion_clock_select_consts.svh"
module test_adc_conversion_sequencer;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trig = 1'b0;
    logic [3:0]  mode = 4'hB;
    logic        cmp;
    logic        tclr;
    logic        samp;
    logic [3:0]  chan;
    logic [11:0] dac;
    logic        done;
    logic [31:0] rd;
    logic        err;
    logic [11:0] lvl;
    int          n_fail = 0;
    int          check_count = 0;
    int          n_clr = 0;
    int          acq;
    int          cv;
    int          divs [7] = '{2, 4, 8, 16, 32, 64, 4};
    logic [2:0]  codes [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int          acqs [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (tclr === 1'b1) n_clr++;
    conversion_clock_select_top #(.RC_DIV(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .special_trigger(trig),
        .compare_mode_field(mode), .comparator_in(cmp), .timer_clear(tclr),
        .sample_enable(samp), .channel_select(chan), .dac_code(dac),
        .conversion_done_flag(done));
    conversion_clock_select_analog_model u_analog (.pclk(pclk), .sample_enable(samp),
        .channel_select(chan), .dac_code(dac), .comparator_in(cmp));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bail();
        n_fail++;
        $display("ERROR %0t wait ran out", $time);
        complete_run();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bail();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // edges with sampling still on, then edges with it off
    task automatic meas();
        acq = 0;
        cv = 0;
        while (samp === 1'b1 && acq < 3000)
        begin
            @(posedge pclk);
            acq++;
        end
        while (samp !== 1'b1 && cv < 3000)
        begin
            @(posedge pclk);
            cv++;
        end
        if (acq >= 3000 || cv >= 3000) bail();
    endtask
    task automatic pulse();
        trig <= 1'b1;
        repeat (4) @(posedge pclk);
        trig <= 1'b0;
        repeat (44) @(posedge pclk);
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`CONVERSION_CLOCK_SELECT_OFF_CTRL0, 32'h0);
        rchk(`CONVERSION_CLOCK_SELECT_OFF_CFG2, 32'h0);
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CFG1, 32'hFF);
        rchk(`CONVERSION_CLOCK_SELECT_OFF_CFG1, 32'h3F);
        apb(1'b0, 12'h018, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 12'h018, 32'h0);
        chk(32'(err), 32'h1);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CFG2, {24'h0, i[0], 4'h0, codes[i]});
            apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CTRL0, {26'h0, 4'(i), 2'h3});
            meas();
            chk(32'(acq < 5), 32'h1);
            chk(32'(cv), 32'(13 * divs[i]));
            chk(32'(done), 32'h1);
            lvl = {4'(i), 8'hA5};
            rchk(`CONVERSION_CLOCK_SELECT_OFF_CTRL0, {26'h0, 4'(i), 2'h1});
            rchk(`CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h1);
            rchk(`CONVERSION_CLOCK_SELECT_OFF_RESH, i[0] ? {28'h0, lvl[11:8]} : {24'h0, lvl[11:4]});
            rchk(`CONVERSION_CLOCK_SELECT_OFF_RESL, i[0] ? {24'h0, lvl[7:0]} : {24'h0, lvl[3:0], 4'h0});
            apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h0);
            repeat (2 * divs[i]) @(posedge pclk);
        end
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CTRL0, 32'h31);
        for (int k = 1; k < 8; k++)
        begin
            apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CFG2, 32'(k << 3));
            apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CTRL0, 32'h33);
            meas();
            chk(32'(acq > 2 * acqs[k] && acq < 2 * acqs[k] + 6), 32'h1);
            rchk(`CONVERSION_CLOCK_SELECT_OFF_RESH, 32'hCA);
            apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h0);
            repeat (4) @(posedge pclk);
        end
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CFG2, 32'h0);
        mode <= 4'h0;
        pulse();
        rchk(`CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h0);
        mode <= 4'hB;
        pulse();
        rchk(`CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h1);
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h0);
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CTRL0, 32'h0);
        pulse();
        rchk(`CONVERSION_CLOCK_SELECT_OFF_STAT, 32'h0);
        chk(32'(n_clr), 32'h2);
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_RESH, 32'hFF);
        rchk(`CONVERSION_CLOCK_SELECT_OFF_RESH, 32'hCA);
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CFG2, 32'h6);
        apb(1'b1, `CONVERSION_CLOCK_SELECT_OFF_CTRL0, 32'h3);
        repeat (100) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`CONVERSION_CLOCK_SELECT_OFF_CTRL0, 32'h0);
        chk(32'(samp), 32'h1);
        rchk(`CONVERSION_CLOCK_SELECT_OFF_RESH, 32'hCA);
        complete_run();
    end
endmodule
`default_nettype wire
